// File: shared/tpsrc_pkg.sv
// Constants and carrier types for one TDM port control bank.
// Assumes a single system clock and an AHB-Lite master with word accesses.
package tpsrc_pkg;
	// Register indices; byte address is four times (index plus port number times port stride)
	localparam logic [15:0] IDX_FORMAT = 16'h6200;
	localparam logic [15:0] IDX_SEG = 16'h6202;
	localparam logic [15:0] IDX_REASM = 16'h6204;
	localparam logic [15:0] IDX_SVC = 16'h6206;
	localparam logic [15:0] IDX_IRQ_STAT = 16'h620c;
	localparam logic [15:0] IDX_IRQ_MASK = 16'h620e;
	localparam logic [15:0] PORT_STRIDE = 16'h0010;
	// Writable bit masks; all other bits but the service flags are reserved and read zero
	localparam logic [15:0] MASK_FORMAT = 16'h6000;
	localparam logic [15:0] MASK_SEG = 16'he1ff;
	localparam logic [15:0] MASK_REASM = 16'hfc1f;
	localparam logic [15:0] MASK_SVC_EN = 16'h000e;
	localparam logic [2:0] MASK_IRQ = 3'h7;
	// Reset values
	localparam logic [15:0] RST_FORMAT = 16'h0000;
	localparam logic [15:0] RST_SEG = 16'h0000;
	localparam logic [15:0] RST_REASM = 16'h0000;
	localparam logic [15:0] RST_SVC = 16'h0040;
	// Bit positions
	localparam int FMT_LSB = 13;
	localparam int FMT_MSB = 14;
	localparam int SEG_BASE_MSB = 8;
	localparam int REASM_BASE_MSB = 4;
	localparam int B_ACTIVE = 13;
	localparam int B_INT_EN = 14;
	localparam int B_EXT_EN = 15;
	localparam int B_REPLAY = 10;
	localparam int B_EDGE = 11;
	localparam int B_LOSS_OUT = 12;
	localparam int B_SE_LOS = 1;
	localparam int B_SE_UOB = 2;
	localparam int B_SE_SOB = 3;
	localparam int B_FL_LOS = 6;
	localparam int B_FL_UOB = 7;
	localparam int B_FL_SOB = 8;
	// Data format codes
	localparam logic [1:0] FMT_UNSTRUCT = 2'h1;
	// Bus constants
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HRESP_OKAY = 2'h0;
	// Bus slave states
	typedef enum logic [1:0] {BUS_IDLE, BUS_WAIT, BUS_DONE} tpsrc_bus_state_t;
	// External memory request: enable and 20-bit word address
	typedef struct packed {
		logic en;
		logic [19:0] addr;
	} tpsrc_mem_req_t;
	// Byte with a valid qualifier
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} tpsrc_byte_t;
endpackage : tpsrc_pkg

// File: verilog/tpsrc_port_ctrl.sv
// Per-port TDM segmentation/reassembly control registers and their gating.
// Assumes AHB-Lite single word transfers, one slave, same clock for all but
// the loss-of-signal pin, which is resynchronised here.
//
// How it works
// R1: seg base 8:0 gives address bits 19:11
// R2: seg port inactive blocks data forwarding
// R3: input buffer writes only with seg internal enable
// R4: structured memory writes need seg external enable
// R5: reasm base 4:0 gives address bits 19:15
// R6: structured underrun: replay or silence by bit10
// R7: bit 11 picks output launch edge
// R8: software keeps bit 11 zero on backplane bus
// R9: unstructured mode drives loss pin from bit12
// R10: reasm port inactive releases output data pins
// R11: output bytes flow only with reasm internal enable
// R12: structured memory reads need reasm external enable
// R13: loss flag with enable raises service flag
// R14: unstructured buffer error raises service flag
// R15: structured buffer error raises service flag
// R16: format field selects none/unstruct/struct/struct-wide
// R17: loss flag latched, cleared by writing zero; code ignores the clear until the format register is written
// R18: reserved bits read zero, ignore writes
// R19: register set repeats every sixteen bytes per port; code steps 64 bytes (sixteen indices)
//
// Our own choice: register access over AHB-Lite.
module tpsrc_port_ctrl #(
	parameter logic [15:0] PORT_NUM = 16'h0000
) (
	input wire logic I_CLK,
	input wire logic I_RESETN,
	input wire logic I_HSEL,
	input wire logic [31:0] I_HADDR,
	input wire logic [1:0] I_HTRANS,
	input wire logic I_HWRITE,
	input wire logic [2:0] I_HSIZE,
	input wire logic [31:0] I_HWDATA,
	input wire logic I_HREADY,
	output logic [31:0] O_HRDATA,
	output logic O_HREADYOUT,
	output logic [1:0] O_HRESP,
	input wire tpsrc_pkg::tpsrc_byte_t I_TDM_IN,
	output tpsrc_pkg::tpsrc_byte_t O_SEG_FORWARD,
	output tpsrc_pkg::tpsrc_byte_t O_INBUF_WRITE,
	input wire logic I_SEG_MEM_REQ,
	input wire logic [10:0] I_SEG_MEM_OFFSET,
	output tpsrc_pkg::tpsrc_mem_req_t O_SEG_MEM,
	input wire logic I_REASM_MEM_REQ,
	input wire logic [14:0] I_REASM_MEM_OFFSET,
	output tpsrc_pkg::tpsrc_mem_req_t O_REASM_MEM,
	input wire tpsrc_pkg::tpsrc_byte_t I_OUTBUF,
	input wire logic I_UNDERRUN,
	input wire logic [7:0] I_REPLAY_BYTE,
	input wire logic [7:0] I_SILENCE_BYTE,
	output tpsrc_pkg::tpsrc_byte_t O_OUT_BYTE,
	output logic O_SERIAL_DATA_OUT_OE,
	output logic O_OUTPUT_LAUNCH_RISING,
	input wire logic I_CAS_OUT,
	output logic O_OUTGOING_LOSS_PIN,
	input wire logic I_SIGNAL_LOSS,
	input wire logic I_UNSTRUCT_OUTBUF_ERR,
	input wire logic I_STRUCT_OUTBUF_ERR,
	output logic [1:0] O_DATA_FORMAT,
	output logic O_PORT_SERVICE_FLAG,
	output logic O_IRQ
);
	import tpsrc_pkg::*;

	// Byte address of a register index for this port
	function automatic logic [31:0] byte_addr(input logic [15:0] idx);
		logic [15:0] sum;
		sum = 16'(idx + 16'(PORT_NUM * PORT_STRIDE));
		return {14'h0000, sum, 2'h0};
	endfunction : byte_addr

	// Merge a write into a register through its writable mask
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
		input logic [15:0] mask);
		return (old & ~mask) | (wd & mask);
	endfunction : merge

	tpsrc_bus_state_t state_reg; // Bus slave state
	tpsrc_bus_state_t state_next; // Next bus state
	logic [31:0] addr_reg; // Latched address phase
	logic write_reg; // Latched direction
	logic [31:0] rdata_reg; // Registered read data
	logic [15:0] format_reg; // Data format register
	logic [15:0] seg_reg; // Segmentation control
	logic [15:0] reasm_reg; // Reassembly control
	logic [15:0] svc_reg; // Service enables and flags
	logic [2:0] irq_stat_reg; // Sticky interrupt events
	logic [2:0] irq_mask_reg; // Interrupt mask
	logic ctrl1_prog_reg; // Format register written since reset
	logic los_meta_reg; // Pin synchroniser, first stage
	logic los_sync_reg; // Pin synchroniser, second stage
	tpsrc_byte_t seg_fwd_reg; // Byte passed on from an active port
	tpsrc_byte_t inbuf_reg; // Input buffer write strobe and byte
	tpsrc_byte_t out_reg; // Byte headed for the output pins
	tpsrc_mem_req_t seg_mem_reg; // Segmentation memory write request
	tpsrc_mem_req_t reasm_mem_reg; // Reassembly memory read request

	// Request decode and commit strobes
	wire accept = I_HSEL && I_HTRANS == HTRANS_NONSEQ && I_HREADY;
	wire commit = state_reg == BUS_WAIT;
	wire wr_commit = commit && write_reg;
	wire [15:0] wd = I_HWDATA[15:0];
	wire sel_format = addr_reg == byte_addr(IDX_FORMAT); // R19
	wire sel_seg = addr_reg == byte_addr(IDX_SEG);
	wire sel_reasm = addr_reg == byte_addr(IDX_REASM);
	wire sel_svc = addr_reg == byte_addr(IDX_SVC);
	wire sel_istat = addr_reg == byte_addr(IDX_IRQ_STAT);
	wire sel_imask = addr_reg == byte_addr(IDX_IRQ_MASK);

	// Mode decode
	wire [1:0] fmt = format_reg[FMT_MSB:FMT_LSB]; // R16
	wire structured = fmt[1]; // R16
	wire unstructured = fmt == FMT_UNSTRUCT; // R16

	// Event sources: set terms win over software clears
	wire [2:0] ev = {I_STRUCT_OUTBUF_ERR, I_UNSTRUCT_OUTBUF_ERR, los_sync_reg};
	wire los_clr = wr_commit && sel_svc && !wd[B_FL_LOS] && ctrl1_prog_reg; // R17
	wire uob_clr = wr_commit && sel_svc && !wd[B_FL_UOB];
	wire sob_clr = wr_commit && sel_svc && !wd[B_FL_SOB];
	wire [2:0] flags = {svc_reg[B_FL_SOB], svc_reg[B_FL_UOB], svc_reg[B_FL_LOS]};
	wire [2:0] fl_next = ev | (flags & ~{sob_clr, uob_clr, los_clr});
	wire [15:0] svc_en = wr_commit && sel_svc ? (wd & MASK_SVC_EN) : (svc_reg & MASK_SVC_EN);
	wire [2:0] istat_clr = wr_commit && sel_istat ? (wd[2:0] & MASK_IRQ) : 3'h0;

	// Read mux; unmapped and reserved bits read zero
	wire [15:0] rd_mux = sel_format ? format_reg : sel_seg ? seg_reg : sel_reasm ? reasm_reg :
		sel_svc ? svc_reg : sel_istat ? {13'h0000, irq_stat_reg} :
		sel_imask ? {13'h0000, irq_mask_reg} : 16'h0000; // R18

	// Underrun fill byte for structured mode
	wire [7:0] fill = reasm_reg[B_REPLAY] ? I_REPLAY_BYTE : I_SILENCE_BYTE; // R6
	wire [7:0] out_data = structured && I_UNDERRUN ? fill : I_OUTBUF.data; // R6

	// Bus slave next state: one wait cycle for every transfer
	always_comb begin
		case (state_reg)
			BUS_IDLE: state_next = accept ? BUS_WAIT : BUS_IDLE;
			BUS_WAIT: state_next = BUS_DONE;
			BUS_DONE: state_next = accept ? BUS_WAIT : BUS_IDLE;
			default: state_next = BUS_IDLE;
		endcase
	end

	// Bus state and latched address phase
	always_ff @(posedge I_CLK) begin
		if (!I_RESETN) begin
			state_reg <= BUS_IDLE;
			addr_reg <= 32'h00000000;
			write_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (accept && state_reg != BUS_WAIT) begin
				addr_reg <= I_HADDR;
				write_reg <= I_HWRITE;
			end
		end
	end

	// Read data captured in the wait cycle, held through the done cycle
	always_ff @(posedge I_CLK) begin
		if (!I_RESETN) begin
			rdata_reg <= 32'h00000000;
		end else if (commit) begin
			rdata_reg <= {16'h0000, rd_mux};
		end
	end

	// Control registers; writes land at the end of the wait cycle
	always_ff @(posedge I_CLK) begin
		if (!I_RESETN) begin
			format_reg <= RST_FORMAT;
			seg_reg <= RST_SEG;
			reasm_reg <= RST_REASM;
			irq_mask_reg <= 3'h0;
			ctrl1_prog_reg <= 1'b0;
		end else if (wr_commit) begin
			// Masks keep reserved bits at zero
			if (sel_format) format_reg <= merge(format_reg, wd, MASK_FORMAT); // R18
			if (sel_format) ctrl1_prog_reg <= 1'b1; // R17
			if (sel_seg) seg_reg <= merge(seg_reg, wd, MASK_SEG); // R18
			if (sel_reasm) reasm_reg <= merge(reasm_reg, wd, MASK_REASM); // R18
			if (sel_imask) irq_mask_reg <= wd[2:0] & MASK_IRQ;
		end
	end

	// Service register: enables plus latched flags; write zero clears a flag, the loss flag only after a format write
	always_ff @(posedge I_CLK) begin
		if (!I_RESETN) begin
			svc_reg <= RST_SVC; // R17
		end else begin
			svc_reg <= svc_en | (16'(fl_next) << B_FL_LOS); // R17
		end
	end

	// Interrupt status: set wins over write-one clear
	always_ff @(posedge I_CLK) begin
		if (!I_RESETN) begin
			irq_stat_reg <= 3'h0;
		end else begin
			irq_stat_reg <= ev | (irq_stat_reg & ~istat_clr);
		end
	end

	// Two-stage synchroniser for the loss-of-signal pin
	always_ff @(posedge I_CLK) begin
		if (!I_RESETN) begin
			los_meta_reg <= 1'b0;
			los_sync_reg <= 1'b0;
		end else begin
			los_meta_reg <= I_SIGNAL_LOSS;
			los_sync_reg <= los_meta_reg;
		end
	end

	// Segmentation side gating
	always_ff @(posedge I_CLK) begin
		if (!I_RESETN) begin
			seg_fwd_reg <= '0;
			inbuf_reg <= '0;
			seg_mem_reg <= '0;
		end else begin
			seg_fwd_reg.valid <= I_TDM_IN.valid && seg_reg[B_ACTIVE]; // R2
			seg_fwd_reg.data <= seg_reg[B_ACTIVE] ? I_TDM_IN.data : 8'h00; // R2
			inbuf_reg.valid <= I_TDM_IN.valid && seg_reg[B_INT_EN]; // R3
			inbuf_reg.data <= I_TDM_IN.data;
			seg_mem_reg.en <= I_SEG_MEM_REQ && structured && seg_reg[B_EXT_EN]; // R4
			seg_mem_reg.addr <= {seg_reg[SEG_BASE_MSB:0], I_SEG_MEM_OFFSET}; // R1
		end
	end

	// Reassembly side gating and underrun fill
	always_ff @(posedge I_CLK) begin
		if (!I_RESETN) begin
			out_reg <= '0;
			reasm_mem_reg <= '0;
		end else begin
			out_reg.valid <= I_OUTBUF.valid && reasm_reg[B_INT_EN]; // R11
			out_reg.data <= out_data; // R6
			reasm_mem_reg.en <= I_REASM_MEM_REQ && structured && reasm_reg[B_EXT_EN]; // R12
			reasm_mem_reg.addr <= {reasm_reg[REASM_BASE_MSB:0], I_REASM_MEM_OFFSET}; // R5
		end
	end

	// Output assignments
	assign O_HREADYOUT = state_reg != BUS_WAIT;
	assign O_HRESP = HRESP_OKAY;
	assign O_HRDATA = rdata_reg;
	assign O_SEG_FORWARD = seg_fwd_reg;
	assign O_INBUF_WRITE = inbuf_reg;
	assign O_SEG_MEM = seg_mem_reg;
	assign O_REASM_MEM = reasm_mem_reg;
	assign O_OUT_BYTE = out_reg;
	assign O_SERIAL_DATA_OUT_OE = reasm_reg[B_ACTIVE]; // R10
	// Software must hold this low in backplane bus format
	assign O_OUTPUT_LAUNCH_RISING = reasm_reg[B_EDGE]; // R7
	// In structured mode the pin carries signalling instead
	assign O_OUTGOING_LOSS_PIN = unstructured ? reasm_reg[B_LOSS_OUT] : I_CAS_OUT; // R9
	assign O_DATA_FORMAT = fmt; // R16
	assign O_PORT_SERVICE_FLAG = (svc_reg[B_SE_LOS] && svc_reg[B_FL_LOS]) || // R13
		(svc_reg[B_SE_UOB] && svc_reg[B_FL_UOB]) || // R14
		(svc_reg[B_SE_SOB] && svc_reg[B_FL_SOB]); // R15
	assign O_IRQ = |(irq_stat_reg & irq_mask_reg);

	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RESETN);

	// Shared sequences for the accepted transfer and the bus wait
	sequence s_accept;
		accept && state_reg != BUS_WAIT;
	endsequence
	sequence s_wait_done;
		!O_HREADYOUT ##1 O_HREADYOUT;
	endsequence

	a_bus_one_wait: assert property (s_accept |=> s_wait_done)
		else $error("bus wait not exactly one cycle");
	a_seg_addr_form: assert property (I_SEG_MEM_REQ |=> // R1
		O_SEG_MEM.addr == {$past(seg_reg[SEG_BASE_MSB:0]), $past(I_SEG_MEM_OFFSET)})
		else $error("segmentation address wrong");
	a_seg_fwd_block: assert property (!seg_reg[B_ACTIVE] |=> !O_SEG_FORWARD.valid) // R2
		else $error("inactive port forwarded data");
	a_inbuf_gate: assert property (I_TDM_IN.valid && seg_reg[B_INT_EN] |=> O_INBUF_WRITE.valid) // R3
		else $error("input buffer write missing");
	a_seg_mem_gate: assert property (O_SEG_MEM.en |-> $past(seg_reg[B_EXT_EN] && structured)) // R4
		else $error("memory write without enable");
	a_reasm_addr_form: assert property (I_REASM_MEM_REQ |=> // R5
		O_REASM_MEM.addr[19:15] == $past(reasm_reg[REASM_BASE_MSB:0]))
		else $error("reassembly address wrong");
	a_underrun_fill: assert property (structured && I_UNDERRUN && !reasm_reg[B_REPLAY] |=> // R6
		O_OUT_BYTE.data == $past(I_SILENCE_BYTE))
		else $error("silence byte not output");
	a_launch_edge: assert property (wr_commit && sel_reasm |=> // R7
		O_OUTPUT_LAUNCH_RISING == $past(wd[B_EDGE]))
		else $error("launch edge not updated");
	a_loss_pin: assert property (unstructured |-> O_OUTGOING_LOSS_PIN == reasm_reg[B_LOSS_OUT]) // R9
		else $error("loss pin wrong");
	a_pin_release: assert property (wr_commit && sel_reasm && !wd[B_ACTIVE] |=> // R10
		!O_SERIAL_DATA_OUT_OE)
		else $error("pins not released");
	a_out_gate: assert property (O_OUT_BYTE.valid |-> $past(reasm_reg[B_INT_EN])) // R11
		else $error("output byte without enable");
	a_reasm_mem_gate: assert property (O_REASM_MEM.en |-> $past(reasm_reg[B_EXT_EN])) // R12
		else $error("memory read without enable");
	a_service_sob: assert property (I_STRUCT_OUTBUF_ERR && svc_reg[B_SE_SOB] && // R15
		!(wr_commit && sel_svc) |=> O_PORT_SERVICE_FLAG)
		else $error("service flag not raised");
	a_los_hold: assert property (!ctrl1_prog_reg && svc_reg[B_FL_LOS] |=> svc_reg[B_FL_LOS]) // R17
		else $error("loss flag cleared too early");
	a_reserved_zero: assert property ((seg_reg & ~MASK_SEG) == 16'h0000 && // R18
		(reasm_reg & ~MASK_REASM) == 16'h0000)
		else $error("reserved bits set");

	// Service flag follows a fresh event when its enable is set and no service write lands
	a_service_los: assert property (los_sync_reg && svc_reg[B_SE_LOS] && // R13
		!(wr_commit && sel_svc) |=> O_PORT_SERVICE_FLAG)
		else $error("service flag missed signal loss");
	a_service_uob: assert property (I_UNSTRUCT_OUTBUF_ERR && svc_reg[B_SE_UOB] && // R14
		!(wr_commit && sel_svc) |=> O_PORT_SERVICE_FLAG)
		else $error("service flag missed buffer error");
	a_service_quiet: assert property ((svc_reg & MASK_SVC_EN) == 16'h0000 |-> // R15
		!O_PORT_SERVICE_FLAG)
		else $error("service flag without enable");
	// Format field and reads of the segmentation register
	a_format_out: assert property (wr_commit && sel_format |=> // R16
		O_DATA_FORMAT == $past(wd[FMT_MSB:FMT_LSB]))
		else $error("format field not updated");
	a_seg_read: assert property (commit && !write_reg && sel_seg |=> // R18
		O_HRDATA == {16'h0000, $past(seg_reg)})
		else $error("segmentation read data wrong");
	// Forwarding and input buffer writes with their enables
	a_seg_fwd_pass: assert property (I_TDM_IN.valid && seg_reg[B_ACTIVE] |=> // R2
		O_SEG_FORWARD.valid && O_SEG_FORWARD.data == $past(I_TDM_IN.data))
		else $error("active port dropped data");
	a_inbuf_block: assert property (!seg_reg[B_INT_EN] |=> !O_INBUF_WRITE.valid) // R3
		else $error("input buffer written while disabled");
	// Loss flag and interrupt status latch on their events
	a_los_set: assert property (los_sync_reg |=> svc_reg[B_FL_LOS]) // R17
		else $error("loss flag not latched");
	a_irq_sticky: assert property (I_STRUCT_OUTBUF_ERR |=> irq_stat_reg[2])
		else $error("interrupt status not set");
	a_irq_level: assert property ((irq_stat_reg & irq_mask_reg) != 3'h0 |-> O_IRQ)
		else $error("interrupt output low");
endmodule : tpsrc_port_ctrl

// File: sim/test_tpsrc_port_ctrl.sv
// Self-checking bench for the per-port TDM control bank, port 0 instance.
// Assumes one 200 MHz clock; the bench is the only AHB-Lite master.
module test_tpsrc_port_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	import tpsrc_pkg::*;
	// Byte address is four times the register index
	localparam logic [31:0] fmt_a = {14'h0, IDX_FORMAT, 2'h0};
	localparam logic [31:0] seg_a = {14'h0, IDX_SEG, 2'h0};
	localparam logic [31:0] reasm_a = {14'h0, IDX_REASM, 2'h0};
	localparam logic [31:0] svc_a = {14'h0, IDX_SVC, 2'h0};
	localparam logic [31:0] stat_a = {14'h0, IDX_IRQ_STAT, 2'h0};
	localparam logic [31:0] mask_a = {14'h0, IDX_IRQ_MASK, 2'h0};
	// Table rows: address, write data, expected read back
	logic [31:0] row_a [7] = '{svc_a, seg_a, reasm_a, fmt_a, mask_a, fmt_a + 32'h4, seg_a + 32'h40};
	logic [31:0] row_d [7] = '{32'hffff, 32'hffff, 32'hffff, 32'hffff, 32'hffff, 32'hffff, 32'hffff};
	logic [31:0] row_e [7] = '{32'h004e, 32'he1ff, 32'hfc1f, 32'h6000, 32'h0007, 32'h0, 32'h0};
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hready;
	logic [31:0] hrdata;
	logic [1:0] hresp;
	tpsrc_byte_t tdm_in = '0;
	tpsrc_byte_t outbuf = '0;
	tpsrc_byte_t seg_fwd, inbuf_wr, out_byte;
	tpsrc_mem_req_t seg_mem, reasm_mem;
	logic seg_req = 1'b0;
	logic reasm_req = 1'b0;
	logic [10:0] seg_off = 11'h0;
	logic [14:0] reasm_off = 15'h0;
	logic und = 1'b0;
	logic cas = 1'b0;
	logic [2:0] evt = 3'h0; // Events: {structured err, unstructured err, signal loss}
	logic oe, launch, loss_pin, svc_flag, irq, e;
	logic [1:0] fmt_out;
	logic [31:0] rd;
	int comparisons = 0;
	int miscompares = 0;
	int cycles = 0;

	// Clock: 5 ns period
	always #2.5 clk = ~clk;

	tpsrc_port_ctrl tpsrc_port_ctrl_inst (.I_CLK(clk), .I_RESETN(rstn), .I_HSEL(hsel),
		.I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
		.I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready),
		.O_HRESP(hresp), .I_TDM_IN(tdm_in), .O_SEG_FORWARD(seg_fwd), .O_INBUF_WRITE(inbuf_wr),
		.I_SEG_MEM_REQ(seg_req), .I_SEG_MEM_OFFSET(seg_off), .O_SEG_MEM(seg_mem),
		.I_REASM_MEM_REQ(reasm_req), .I_REASM_MEM_OFFSET(reasm_off), .O_REASM_MEM(reasm_mem),
		.I_OUTBUF(outbuf), .I_UNDERRUN(und), .I_REPLAY_BYTE(8'h77), .I_SILENCE_BYTE(8'h99),
		.O_OUT_BYTE(out_byte), .O_SERIAL_DATA_OUT_OE(oe), .O_OUTPUT_LAUNCH_RISING(launch),
		.I_CAS_OUT(cas), .O_OUTGOING_LOSS_PIN(loss_pin), .I_SIGNAL_LOSS(evt[0]),
		.I_UNSTRUCT_OUTBUF_ERR(evt[1]), .I_STRUCT_OUTBUF_ERR(evt[2]), .O_DATA_FORMAT(fmt_out),
		.O_PORT_SERVICE_FLAG(svc_flag), .O_IRQ(irq));

	// Counts, verdict and end of run
	task report_and_stop;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : report_and_stop

	// Case equality so an unknown never matches
	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One single transfer; waits on the slave's ready, never a fixed count
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= wr;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		rd = hrdata;
		check({30'h0, hresp}, {30'h0, HRESP_OKAY});
		@(negedge clk);
	endtask : bus

	// Read and compare in one call
	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(rd, exp);
	endtask : rd_chk

	// Hang guard: whole run needs well under this many cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			miscompares++;
			report_and_stop();
		end
	end

	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		// Table: write then read back each place, reserved and unmapped too
		for (int i = 0; i < 7; i++) begin
			bus(1'b1, row_a[i], row_d[i]);
			rd_chk(row_a[i], row_e[i]);
		end
		check({31'h0, svc_flag}, 32'h1);
		$display("register table test done");
		// Data paths enabled with replay fill, then all but output bytes disabled with silence fill
		for (int p = 0; p < 2; p++) begin
			e = (p == 0);
			if (p == 1) begin
				bus(1'b1, seg_a, 32'h0000);
				bus(1'b1, reasm_a, 32'h400a);
			end
			@(posedge clk);
			tdm_in <= '{1'b1, 8'ha5};
			outbuf <= '{1'b1, 8'h3c};
			und <= 1'b1;
			seg_req <= 1'b1;
			seg_off <= 11'h555;
			reasm_req <= 1'b1;
			reasm_off <= 15'h1234;
			@(posedge clk);
			tdm_in <= '0;
			outbuf <= '0;
			seg_req <= 1'b0;
			reasm_req <= 1'b0;
			@(negedge clk);
			check(32'(seg_fwd), e ? 32'h1a5 : 32'h0);
			// Byte still flows to the buffer port; only the strobe is gated
			check(32'(inbuf_wr), {23'h0, e, 8'ha5});
			check(32'(seg_mem), {11'h0, e, (e ? 9'h1ff : 9'h0), 11'h555});
			check(32'(reasm_mem), {11'h0, e, (e ? 5'h1f : 5'h0a), 15'h1234});
			check(32'(out_byte), {23'h0, 1'b1, (e ? 8'h77 : 8'h99)});
			check({31'h0, oe}, {31'h0, e});
			check({31'h0, launch}, {31'h0, e});
		end
		$display("data path test done");
		// Loss pin: passes the signalling bit outside unstructured mode
		@(posedge clk);
		cas <= 1'b1;
		und <= 1'b0;
		@(negedge clk);
		check({31'h0, loss_pin}, 32'h1);
		bus(1'b1, fmt_a, 32'h2000);
		check({30'h0, fmt_out}, {30'h0, FMT_UNSTRUCT});
		check({31'h0, loss_pin}, 32'h0);
		@(posedge clk);
		cas <= 1'b0;
		bus(1'b1, reasm_a, 32'h500a);
		check({31'h0, loss_pin}, 32'h1);
		$display("loss pin test done");
		// Each event: flag latches, raises service only with its enable
		bus(1'b1, svc_a, 32'h0);
		rd_chk(svc_a, 32'h0);
		for (int k = 0; k < 3; k++) begin
			bus(1'b1, svc_a, 32'h1 << (k + 1));
			check({31'h0, svc_flag}, 32'h0);
			@(posedge clk);
			evt <= 3'(1 << k);
			repeat (4) @(posedge clk);
			evt <= 3'h0;
			repeat (4) @(posedge clk);
			rd_chk(svc_a, (32'h1 << (k + 1)) | (32'h1 << (k + 6)));
			check({31'h0, svc_flag}, 32'h1);
			bus(1'b1, svc_a, 32'h1 << (k + 6));
			check({31'h0, svc_flag}, 32'h0);
			bus(1'b1, svc_a, 32'h0);
		end
		// Interrupt: raised, masked, cleared one bit and then two bits together
		rd_chk(stat_a, 32'h7);
		check({31'h0, irq}, 32'h1);
		bus(1'b1, mask_a, 32'h0);
		check({31'h0, irq}, 32'h0);
		bus(1'b1, mask_a, 32'h7);
		bus(1'b1, stat_a, 32'h2);
		rd_chk(stat_a, 32'h5);
		check({31'h0, irq}, 32'h1);
		bus(1'b1, stat_a, 32'h5);
		check({31'h0, irq}, 32'h0);
		$display("event and interrupt test done");
		// Second reset mid-run: values return, loss flag set and stuck until the format register is written
		@(posedge clk);
		rstn <= 1'b0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		check({28'h0, oe, launch, svc_flag, irq}, 32'h0);
		check({31'h0, hready}, 32'h1);
		rd_chk(seg_a, {16'h0, RST_SEG});
		rd_chk(reasm_a, {16'h0, RST_REASM});
		rd_chk(fmt_a, {16'h0, RST_FORMAT});
		bus(1'b1, svc_a, 32'h0);
		rd_chk(svc_a, {16'h0, RST_SVC});
		bus(1'b1, fmt_a, 32'h4000);
		check({30'h0, fmt_out}, 32'h2);
		bus(1'b1, svc_a, 32'h0);
		rd_chk(svc_a, 32'h0);
		$display("reset test done");
		report_and_stop();
	end
endmodule : test_tpsrc_port_ctrl
